// [design/arc_rate_clock_control.v]
`timescale 1ns/100ps
`include "arc_regs.vh"

module arc_rate_clock_control #(
   parameter DATA_WIDTH = 16
) (
   input wire clock,
   input wire rst_n,
   input wire csN,
   input wire sclk,
   input wire din,
   input wire external_clock_select,
   input wire [DATA_WIDTH-1:0] filterData,
   input wire [3:0] gpioIn,
   output reg rdyDout,
   output reg sampleStrobe,
   output reg convActive,
   output wire inputBufferEnable,
   output wire unipolarSelect,
   output wire singleShotSelect,
   output wire externalClockSelect,
   output wire lineFreqSelect,
   output wire [3:0] gpioOut,
   output wire [3:0] gpioOeN
);

   // phase increments: oscillator frequency as a fraction of the reference times 2^32
   localparam [31:0] INC_HIGH = $rtoi(`ARC_OSC_HIGH_HZ / `ARC_REF_CLOCK_HZ * 4294967296.0);
   localparam [31:0] INC_LOW = $rtoi(`ARC_OSC_LOW_HZ / `ARC_REF_CLOCK_HZ * 4294967296.0);

   localparam [1:0] CV_IDLE = 2'b01;
   localparam [1:0] CV_RUN = 2'b10;
   localparam [3:0] FR_CMD = 4'b0001;
   localparam [3:0] FR_WDATA = 4'b0010;
   localparam [3:0] FR_READ = 4'b0100;
   localparam [3:0] FR_SKIP = 4'b1000;

   function [17:0] decimRatio;
      input single;
      input [2:0] code;
      begin
         case ({single, code})
            4'h4: decimRatio = `ARC_DEC_4096;
            4'h5: decimRatio = `ARC_DEC_2048;
            4'h6: decimRatio = `ARC_DEC_1024;
            4'h7: decimRatio = `ARC_DEC_512;
            4'h8: decimRatio = `ARC_DEC_245760;
            4'h9: decimRatio = `ARC_DEC_98304;
            4'hA: decimRatio = `ARC_DEC_49152;
            4'hB: decimRatio = `ARC_DEC_24576;
            4'hC: decimRatio = `ARC_DEC_16384;
            4'hD: decimRatio = `ARC_DEC_8192;
            4'hE: decimRatio = `ARC_DEC_4096;
            4'hF: decimRatio = `ARC_DEC_2048;
            // codes 0-3 have no continuous rate; run them at the slowest one
            default: decimRatio = `ARC_DEC_4096;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   reg [1:0] csSync;
   reg [1:0] sclkSync;
   reg [1:0] dinSync;
   reg [1:0] extSync;
   reg [3:0] gpioSync1;
   reg [3:0] gpioSync2;
   reg sclkPrev;
   reg extPrev;

   always @(posedge clock) begin
      if (!rst_n) begin
         csSync <= 2'h3;
         // sclk rests high, so a low reset value would fake a rising edge
         sclkSync <= 2'h3;
         dinSync <= 2'h0;
         extSync <= 2'h0;
         gpioSync1 <= 4'h0;
         gpioSync2 <= 4'h0;
         sclkPrev <= 1'b1;
         extPrev <= 1'b0;
      end else begin
         csSync <= {csSync[0], csN};
         sclkSync <= {sclkSync[0], sclk};
         dinSync <= {dinSync[0], din};
         extSync <= {extSync[0], external_clock_select};
         gpioSync1 <= gpioIn;
         gpioSync2 <= gpioSync1;
         sclkPrev <= sclkSync[1];
         extPrev <= extSync[1];
      end
   end

   wire csLow = ~csSync[1];
   wire sclkRise = sclkSync[1] & ~sclkPrev;
   wire sclkFall = ~sclkSync[1] & sclkPrev;
   wire dinBit = dinSync[1];

   ////////////////////////////////////////////////////////////////////////////////
   // configuration registers

   reg [7:0] firstControl;
   reg [7:0] generalPins;
   reg [3:0] pinDriveN;

   assign singleShotSelect = firstControl[`ARC_SINGLE_SHOT_BIT];
   assign unipolarSelect = firstControl[`ARC_UNIPOLAR_BIT];
   assign inputBufferEnable = firstControl[`ARC_INPUT_BUFFER_BIT];
   assign externalClockSelect = firstControl[`ARC_EXT_CLOCK_BIT];
   assign lineFreqSelect = firstControl[`ARC_LINE_FREQ_BIT];
   assign gpioOut = generalPins[`ARC_PIN_LEVEL_LSB +: 4];
   assign gpioOeN = pinDriveN;

   ////////////////////////////////////////////////////////////////////////////////
   // system clock: internal oscillator model or external clock edges

   reg [31:0] phaseAcc;
   reg intTick;
   reg [3:0] sampleDivCnt;
   wire [31:0] phaseInc = lineFreqSelect ? INC_LOW : INC_HIGH;
   wire [32:0] phaseSum = {1'b0, phaseAcc} + {1'b0, phaseInc};
   // an external frequency up to half the clock just changes the tick rate, so every rate scales with it
   wire sysTick = externalClockSelect ? (extSync[1] & ~extPrev) : intTick;

   always @(posedge clock) begin
      if (!rst_n) begin
         phaseAcc <= 32'h00000000;
         intTick <= 1'b0;
         sampleDivCnt <= 4'h0;
         sampleStrobe <= 1'b0;
      end else begin
         phaseAcc <= phaseSum[31:0];
         intTick <= phaseSum[32];
         sampleStrobe <= 1'b0;
         if (sysTick) begin
            if (sampleDivCnt == `ARC_SAMPLE_DIV - 4'h1) begin
               sampleDivCnt <= 4'h0;
               sampleStrobe <= 1'b1;
            end else begin
               sampleDivCnt <= sampleDivCnt + 4'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // serial frame

   reg [3:0] frame;
   reg [4:0] bitCnt;
   reg [6:0] shiftIn;
   reg [15:0] shiftOut;
   reg writeAddr;
   reg [2:0] rateCode;
   reg convStart;
   reg readTaken;
   reg [DATA_WIDTH-1:0] result;
   reg dataReady;
   wire [7:0] rxByte = {shiftIn, dinBit};

   always @(posedge clock) begin
      if (!rst_n) begin
         frame <= FR_CMD;
         bitCnt <= 5'h00;
         shiftIn <= 7'h00;
         shiftOut <= 16'h0000;
         writeAddr <= 1'b0;
         rateCode <= 3'h0;
         convStart <= 1'b0;
         readTaken <= 1'b0;
         firstControl <= `ARC_FIRST_CONTROL_RESET;
         generalPins <= `ARC_GENERAL_PINS_RESET;
         pinDriveN <= `ARC_PIN_DRIVE_RESET;
         rdyDout <= 1'b1;
      end else begin
         convStart <= 1'b0;
         readTaken <= 1'b0;
         if (!csLow || frame != FR_READ) begin
            rdyDout <= ~dataReady;
         end else if (sclkFall) begin
            rdyDout <= shiftOut[15];
            shiftOut <= {shiftOut[14:0], 1'b0};
         end
         if (!csLow) begin
            frame <= FR_CMD;
            bitCnt <= 5'h00;
         end else if (sclkRise) begin
            bitCnt <= bitCnt + 5'h01;
            if (frame == FR_CMD || frame == FR_WDATA) begin
               shiftIn <= rxByte[6:0];
            end
            case (frame)
               FR_CMD: begin
                  if (bitCnt == 5'h07) begin
                     case (rxByte[7:6])
                        `ARC_CMD_WRITE: begin
                           writeAddr <= rxByte[`ARC_CMD_ADDR_BIT];
                           frame <= FR_WDATA;
                        end
                        `ARC_CMD_READ_DATA: begin
                           shiftOut <= result;
                           readTaken <= 1'b1;
                           frame <= FR_READ;
                        end
                        `ARC_CMD_CONVERT: begin
                           rateCode <= rxByte[2:0];
                           convStart <= 1'b1;
                           frame <= FR_SKIP;
                        end
                        default: begin
                           shiftOut <= {gpioSync2, generalPins[`ARC_PIN_DIR_LSB +: 4], 8'h00};
                           frame <= FR_READ;
                        end
                     endcase
                  end
               end
               FR_WDATA: begin
                  if (bitCnt == 5'h0F) begin
                     if (writeAddr == `ARC_ADDR_FIRST_CONTROL) begin
                        firstControl <= rxByte;
                     end else begin
                        generalPins <= rxByte;
                        pinDriveN <= ~rxByte[`ARC_PIN_DIR_LSB +: 4];
                     end
                     frame <= FR_SKIP;
                  end
               end
               FR_READ: begin
               end
               FR_SKIP: begin
               end
               default: frame <= FR_SKIP;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // conversion sequencer

   reg [1:0] convState;
   reg [17:0] decimCnt;
   wire [17:0] decimEnd = decimRatio(singleShotSelect, rateCode) - 18'h00001;
   wire convDone = convState == CV_RUN && sampleStrobe && decimCnt == decimEnd;
   wire [1:0] next_convState = convStart ? CV_RUN :
      (convDone && singleShotSelect) ? CV_IDLE : convState;
   // a new result in the same cycle as a read keeps the ready flag set
   wire next_dataReady = convDone | (dataReady & ~readTaken);

   always @(posedge clock) begin
      if (!rst_n) begin
         convState <= CV_IDLE;
         decimCnt <= 18'h00000;
         result <= {DATA_WIDTH{1'b0}};
         dataReady <= 1'b0;
         convActive <= 1'b0;
      end else begin
         convState <= next_convState;
         dataReady <= next_dataReady;
         convActive <= next_convState == CV_RUN;
         if (convStart || convDone) begin
            decimCnt <= 18'h00000;
         end else if (convState == CV_RUN && sampleStrobe) begin
            decimCnt <= decimCnt + 18'h00001;
         end
         if (convDone) begin
            result <= filterData;
         end
      end
   end

endmodule // arc_rate_clock_control

// [design/arc_regs.vh]
`ifndef ARC_REGS_VH
`define ARC_REGS_VH

// command byte: top two bits pick the action, low three bits carry the rate code
`define ARC_CMD_WRITE 2'h0
`define ARC_CMD_READ_DATA 2'h1
`define ARC_CMD_CONVERT 2'h2
`define ARC_CMD_READ_PINS 2'h3
`define ARC_CMD_ADDR_BIT 0

// register addresses carried in bit 0 of a write command
`define ARC_ADDR_FIRST_CONTROL 1'h0
`define ARC_ADDR_GENERAL_PINS 1'h1

// first control register fields
`define ARC_SINGLE_SHOT_BIT 0
`define ARC_UNIPOLAR_BIT 1
`define ARC_INPUT_BUFFER_BIT 2
`define ARC_EXT_CLOCK_BIT 3
`define ARC_LINE_FREQ_BIT 4
`define ARC_FIRST_CONTROL_RESET 8'h01

// general pin register: direction in the upper nibble, level in the lower
`define ARC_PIN_DIR_LSB 4
`define ARC_PIN_LEVEL_LSB 0
`define ARC_GENERAL_PINS_RESET 8'h00
`define ARC_PIN_DRIVE_RESET 4'hF

// oscillator rates in Hz and the 100 MHz reference clock
`define ARC_REF_CLOCK_HZ 100000000.0
`define ARC_OSC_HIGH_HZ 2457600.0
`define ARC_OSC_LOW_HZ 2048000.0
`define ARC_SAMPLE_DIV 4'hA

// decimation ratios in modulator samples per output word
`define ARC_DEC_2048 18'h00800
`define ARC_DEC_4096 18'h01000
`define ARC_DEC_8192 18'h02000
`define ARC_DEC_16384 18'h04000
`define ARC_DEC_24576 18'h06000
`define ARC_DEC_49152 18'h0C000
`define ARC_DEC_98304 18'h18000
`define ARC_DEC_245760 18'h3C000
`define ARC_DEC_512 18'h00200
`define ARC_DEC_1024 18'h00400

`endif

// [test/arc_host_model.sv]
`timescale 1ns/100ps
module arc_host_model (
   input wire clock,
   input wire rdyDout,
   output reg csN,
   output reg sclk,
   output reg din
);
   initial begin
      csN = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   // sclk rests high between frames; din flips after a frame so stale data never looks valid
   task xfer(input [23:0] bits, input integer n, output [15:0] rd);
      integer i;
      begin
         rd = 16'h0000;
         @(posedge clock);
         #1 csN = 1'b0;
         for (i = n - 1; i >= 0; i = i - 1) begin
            repeat (5) @(posedge clock);
            #1 sclk = 1'b0;
            din = bits[i];
            repeat (5) @(posedge clock);
            #1 rd = {rd[14:0], rdyDout};
            sclk = 1'b1;
         end
         repeat (5) @(posedge clock);
         #1 csN = 1'b1;
         din = ~din;
         repeat (5) @(posedge clock);
         #1;
      end
   endtask
endmodule // arc_host_model

// [test/arc_rate_clock_control_props.sv]
`timescale 1ns/100ps
module arc_rate_clock_control_props (
   input wire clock,
   input wire rst_n,
   input wire csN,
   input wire sclk,
   input wire rdyDout,
   input wire sampleStrobe,
   input wire convActive,
   input wire inputBufferEnable,
   input wire unipolarSelect,
   input wire singleShotSelect,
   input wire externalClockSelect,
   input wire lineFreqSelect,
   input wire [3:0] gpioOut,
   input wire [3:0] gpioOeN
);
   reg [9:0] gap;
   reg [1:0] runs;
   reg [1:0] oscRuns;
   reg lineFreqPrev;
   wire [12:0] cfg;
   assign cfg = {inputBufferEnable, unipolarSelect, singleShotSelect, externalClockSelect,
      lineFreqSelect, gpioOut, gpioOeN};
   // the first gap after a mode change is partial, so two strobes must pass first
   always @(posedge clock) begin
      if (!rst_n || !externalClockSelect) runs <= 2'h0;
      else if (sampleStrobe && runs != 2'h3) runs <= runs + 2'h1;
      lineFreqPrev <= lineFreqSelect;
      if (!rst_n || externalClockSelect || lineFreqSelect != lineFreqPrev) oscRuns <= 2'h0;
      else if (sampleStrobe && oscRuns != 2'h3) oscRuns <= oscRuns + 2'h1;
      if (sampleStrobe) gap <= 10'h000;
      else if (gap != 10'h3FF) gap <= gap + 10'h001;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_reset_state: assert property ($rose(rst_n) |-> rdyDout && !convActive &&
      !sampleStrobe && cfg == 13'h040F) else $error("state after reset wrong");
   a_strobe_pulse: assert property (sampleStrobe |=> !sampleStrobe)
      else $error("sample strobe longer than one cycle");
   a_strobe_gap: assert property (sampleStrobe && runs[1] |-> gap == 10'h013)
      else $error("sample strobe not every ten external ticks");
   a_config_hold: assert property (csN && $past(csN) |-> $stable(cfg))
      else $error("configuration changed outside a frame");
   a_conv_in_frame: assert property ($rose(convActive) |-> !csN)
      else $error("conversion started without a command");
   a_ready_cause: assert property ($fell(rdyDout) && csN && $past(csN, 4) |->
      convActive || $past(convActive) || $past(convActive, 2)) else $error("ready without result");
   a_idle_no_rise: assert property (csN [*6] |-> !$rose(rdyDout))
      else $error("ready withdrawn while idle");
   a_dout_on_fall: assert property ((sclk && !csN && !convActive) [*4] |-> $stable(rdyDout))
      else $error("data out moved while serial clock high");
   // ten oscillator ticks of 100 MHz clocks: 406.9 at the high rate, 488.3 at the low one
   a_osc_gap: assert property (sampleStrobe && oscRuns[1] |-> (lineFreqSelect ?
      (gap == 10'h1E7 || gap == 10'h1E8) : (gap == 10'h195 || gap == 10'h196)))
      else $error("internal sample strobe spacing wrong");
   c_result: cover property ($fell(rdyDout) && csN);
   c_osc_gap: cover property (sampleStrobe && oscRuns[1] && lineFreqSelect);
   c_ext_gap: cover property (sampleStrobe && runs[1]);
   c_conv: cover property ($rose(convActive));
endmodule // arc_rate_clock_control_props

// [test/arc_rate_clock_control_tb.sv]
`timescale 1ns/100ps
module arc_rate_clock_control_tb;
   reg clock = 1'b0;
   reg rst_n = 1'b0;
   reg external_clock_select = 1'b0;
   reg [15:0] filterData = 16'h0000;
   reg [3:0] gpioIn = 4'h0;
   wire csN, sclk, din, rdyDout, sampleStrobe, convActive;
   wire inputBufferEnable, unipolarSelect, singleShotSelect, externalClockSelect, lineFreqSelect;
   wire [3:0] gpioOut, gpioOeN;
   wire [4:0] cfg5;
   integer miscompares = 0;
   integer samples_checked = 0;
   integer seed = 32'h9FE4;
   integer strobes = 0;
   integer convStrobes = 0;
   integer i, s0;
   reg [15:0] rd;
   reg [7:0] v;
   assign cfg5 = {lineFreqSelect, externalClockSelect, inputBufferEnable, unipolarSelect,
      singleShotSelect};
   always #5 clock = ~clock;
   // external clock at half the system clock keeps conversions short; rates scale with it
   always #10 external_clock_select = ~external_clock_select;
   always @(posedge clock) if (sampleStrobe === 1'b1) strobes <= strobes + 1;
   // strobes the sequencer consumes: those seen while it runs
   always @(posedge clock) if (sampleStrobe === 1'b1 && convActive === 1'b1)
      convStrobes <= convStrobes + 1;
   arc_rate_clock_control DUT (.clock(clock), .rst_n(rst_n), .csN(csN), .sclk(sclk), .din(din),
      .external_clock_select(external_clock_select), .filterData(filterData), .gpioIn(gpioIn), .rdyDout(rdyDout),
      .sampleStrobe(sampleStrobe), .convActive(convActive), .inputBufferEnable(inputBufferEnable),
      .unipolarSelect(unipolarSelect), .singleShotSelect(singleShotSelect),
      .externalClockSelect(externalClockSelect), .lineFreqSelect(lineFreqSelect),
      .gpioOut(gpioOut), .gpioOeN(gpioOeN));
   arc_host_model host (.clock(clock), .rdyDout(rdyDout), .csN(csN), .sclk(sclk), .din(din));
   ////////////////////////////////////////////////////////////////////////////
   task check(input [15:0] seen, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task wait_rdy;
      integer k;
      begin
         k = 0;
         while (rdyDout !== 1'b0 && k < 45000) begin
            @(posedge clock);
            #1 k = k + 1;
         end
         if (k == 45000) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t no result", $time);
            final_report;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clock);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clock);
      #1 check({rdyDout, convActive, cfg5}, 16'h0041);
      check({gpioOeN, gpioOut}, 16'h00F0);
      $display("test reset done");
      for (i = 0; i < 8; i = i + 1) begin
         v = (i == 0) ? 8'h1F : (i == 1) ? 8'h00 : $random(seed);
         host.xfer({16'h0000, v}, 16, rd);
         check(cfg5, v[4:0]);
         v = $random(seed);
         host.xfer({16'h0001, v}, 16, rd);
         check({gpioOeN, gpioOut}, {~v[7:4], v[3:0]});
         gpioIn = $random(seed);
         host.xfer({8'hC0, 16'h0000}, 24, rd);
         check(rd, {gpioIn, v[7:4], 8'h00});
      end
      $display("test config and pins done");
      // internal oscillator at each line frequency; the checker times the strobes
      host.xfer({16'h0000, 8'h00}, 16, rd);
      repeat (1300) @(posedge clock);
      #1 check(lineFreqSelect, 1'b0);
      host.xfer({16'h0000, 8'h10}, 16, rd);
      repeat (1600) @(posedge clock);
      #1 check(lineFreqSelect, 1'b1);
      $display("test oscillator done");
      host.xfer({16'h0000, 8'h09}, 16, rd);
      s0 = convStrobes;
      filterData = $random(seed);
      host.xfer({16'h0000, 8'h87}, 8, rd);
      wait_rdy;
      check(convStrobes - s0, 16'h0800);
      check(convActive, 1'b0);
      host.xfer({8'h40, 16'h0000}, 24, rd);
      check(rd, filterData);
      $display("test single conversion done");
      host.xfer({16'h0000, 8'h08}, 16, rd);
      filterData = $random(seed);
      host.xfer({16'h0000, 8'h87}, 8, rd);
      wait_rdy;
      s0 = strobes;
      host.xfer({8'h40, 16'h0000}, 24, rd);
      check(rd, filterData);
      repeat (5) @(posedge clock);
      #1 check(rdyDout, 1'b1);
      wait_rdy;
      check(strobes - s0, 16'h0200);
      $display("test conversion done");
      final_report;
   end
endmodule // arc_rate_clock_control_tb

bind arc_rate_clock_control arc_rate_clock_control_props chk (.clock(clock), .rst_n(rst_n),
   .csN(csN), .sclk(sclk), .rdyDout(rdyDout), .sampleStrobe(sampleStrobe),
   .convActive(convActive), .inputBufferEnable(inputBufferEnable),
   .unipolarSelect(unipolarSelect), .singleShotSelect(singleShotSelect),
   .externalClockSelect(externalClockSelect), .lineFreqSelect(lineFreqSelect),
   .gpioOut(gpioOut), .gpioOeN(gpioOeN));
